/* File: rtl/shra_defines.svh */
// named constants of the sensor host register access front end
`ifndef SHRA_DEFINES_SVH
`define SHRA_DEFINES_SVH
`define SHRA_BYTE_BITS      4'h8
`define SHRA_ADDR_FIXED     5'h07
`define SHRA_FACTORY_Y      1'b1
`define SHRA_HS_CODE        5'h01
`define SHRA_BUF_READ_ADDR  8'h5F
`define SHRA_ADDR_STEP      8'h01
`define SHRA_SPI_ADDR_LAST  5'h07
`define SHRA_SPI_DATA_FIRST 5'h08
`define SHRA_SPI_ADV_BIT    5'h0B
`define SHRA_SPI_LAST       5'h0F
`define SHRA_SPI_DONE       5'h10
`endif

/* File: rtl/shra_pkg.sv */
// types of the sensor host register access front end
package shra_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_DEV  = 4'h1,
        S_DACK = 4'h3,
        S_RA   = 4'h2,
        S_RACK = 4'h6,
        S_WDAT = 4'h7,
        S_WACK = 4'h5,
        S_RDAT = 4'h4,
        S_MACK = 4'hC,
        S_SKIP = 4'hD
    } shra_i2c_state_t;
endpackage

/* File: rtl/shra_sync2.sv */
// two-stage synchroniser for levels and toggles
`timescale 1ns/100ps
module shra_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule // shra_sync2

/* File: rtl/shra_spi_link.sv */
// 4-wire spi slave engine on the serial clock
`timescale 1ns/100ps
`include "shra_defines.svh"
module shra_spi_link (
    input  wire logic       sclk,
    input  wire logic       rst_n,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    input  wire logic [7:0] rd_data,
    output logic      [7:0] rd_addr,
    output logic      [7:0] wr_addr,
    output logic      [7:0] wr_data,
    output logic            wr_tgl,
    output logic            adv_tgl,
    output logic            sdo_o,
    output logic            sdo_oe
);
    logic       arst_n;
    logic [4:0] cnt_ff;
    logic [6:0] sh_ff;
    logic       read_ff;
    logic       wr_done_ff;
    logic [7:0] tx_ff;
    logic       buf_sel;

    assign arst_n  = rst_n & ~cs_n;
    assign buf_sel = read_ff && (rd_addr == `SHRA_BUF_READ_ADDR);
    assign sdo_o   = tx_ff[7];

    // bit counter and receive shifter, cleared while deselected
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff     <= 5'h00;
            sh_ff      <= 7'h00;
            read_ff    <= 1'b0;
            rd_addr    <= 8'h00;
            wr_done_ff <= 1'b0;
        end else begin
            sh_ff <= {sh_ff[5:0], mosi}; // RULE17
            if (cnt_ff == `SHRA_SPI_LAST) begin
                cnt_ff     <= buf_sel ? `SHRA_SPI_DATA_FIRST : `SHRA_SPI_DONE; // RULE8
                wr_done_ff <= 1'b1;
            end else if (cnt_ff != `SHRA_SPI_DONE) begin
                cnt_ff <= 5'(cnt_ff + 5'h01);
            end
            if (cnt_ff == `SHRA_SPI_ADDR_LAST) begin
                read_ff <= sh_ff[6]; // RULE14
                rd_addr <= {1'b0, sh_ff[5:0], mosi};
            end
        end
    end

    // write and buffer events leave as toggles
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            wr_tgl  <= 1'b0;
            adv_tgl <= 1'b0;
        end else begin
            if (cnt_ff == `SHRA_SPI_LAST && !read_ff && !wr_done_ff) begin // RULE15
                wr_addr <= rd_addr;
                wr_data <= {sh_ff, mosi};
                wr_tgl  <= ~wr_tgl;
            end
            if (cnt_ff == `SHRA_SPI_ADV_BIT && buf_sel) begin // RULE8
                adv_tgl <= ~adv_tgl;
            end
        end
    end

    // output shifter on falling edges, high impedance when deselected
    always_ff @(negedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ff  <= 8'h00;
            sdo_oe <= 1'b0; // RULE12
        end else if (cnt_ff == `SHRA_SPI_DATA_FIRST && read_ff) begin
            tx_ff  <= rd_data; // RULE16
            sdo_oe <= 1'b1;
        end else begin
            tx_ff <= {tx_ff[6:0], 1'b0}; // RULE17
        end
    end

    AST_SPI_WRITE_ONCE: assert property (@(posedge sclk) disable iff (!rst_n) // RULE15
        (cnt_ff == `SHRA_SPI_LAST && !read_ff && !wr_done_ff) |=> (wr_tgl != $past(wr_tgl)))
        else $error("spi write did not raise its event after 16 clocks");
endmodule // shra_spi_link

/* File: rtl/shra_front_end.sv */
// i2c and spi slave front end for the sensor registers
// How it works
// [RULE1] i2c write: start, address byte with write, register address, data; all acked
// [RULE2] host keeps register address lsb zero on i2c
// [RULE3] register address steps after every acked written data byte
// [RULE4] host must not stop during last data bit or its ack
// [RULE5] i2c read: address write, register address, repeated start, read address, data
// [RULE6] host acks bytes it wants continued, nacks the last, then stops
// [RULE7] read burst steps register address after each host ack
// [RULE8] buffer read port holds address and advances buffer pointer per byte
// [RULE9] host reads output registers in one auto-increment burst
// [RULE10] start plus master code 00001xxx with nack enters high-speed mode
// [RULE11] any stop returns the device to fast mode
// [RULE12] spi data output released whenever chip select is high
// [RULE13] host drives chip select low per transfer, high at its end
// [RULE14] spi address byte msb selects direction, one means read
// [RULE15] spi write is address then data, sixteen clocks from chip select fall
// [RULE16] spi read shifts out the addressed register byte after the address
// [RULE17] spi bits travel most significant first both ways
// [RULE18] host raises chip select between requests except buffer streaming
// [RULE19] slave address is 00111yx, x from the address select pin
// [RULE20] addressed before startup completes, the device nacks
// [RULE21] foreign slave addresses are ignored, data line left released
`timescale 1ns/100ps
`include "shra_defines.svh"
module shra_front_end (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       SCLK,
    input  wire logic       CHIP_SELECT_N,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE,
    output logic            SDO_O,
    output logic            SDO_OE,
    input  wire logic       ADDR_SELECT,
    input  wire logic       STARTUP_DONE,
    output logic      [7:0] REG_ADDR,
    input  wire logic [7:0] REG_RDATA,
    output logic      [7:0] REG_WDATA,
    output logic            REG_WR,
    output logic            BUF_ADV,
    output logic      [7:0] SPI_RD_ADDR,
    input  wire logic [7:0] SPI_RD_DATA,
    output logic            HS_MODE
);
    shra_pkg::shra_i2c_state_t state_ff;
    shra_pkg::shra_i2c_state_t nxt_state;
    logic [3:0] pin_s;
    logic [1:0] tgl_s;
    logic       scl_q_ff;
    logic       sda_q_ff;
    logic [1:0] tgl_q_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic       rw_ff;
    logic       mack_ok_ff;
    logic       addr_x_ff;
    logic       strap_done_ff;
    logic [7:0] spi_wr_addr;
    logic [7:0] spi_wr_data;
    logic       spi_wr_tgl;
    logic       spi_adv_tgl;
    logic       scl_s;
    logic       sda_s;
    logic       i2c_en;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       byte_end;
    logic       dev_hit;
    logic       hs_code;
    logic       spi_wr_ev;
    logic       spi_adv_ev;
    logic       at_buf;

    shra_sync2 #(.W(4)) u_pin_sync (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     ({SCLK, SDA_I, CHIP_SELECT_N, ADDR_SELECT}),
        .q     (pin_s)
    );

    shra_sync2 #(.W(2)) u_tgl_sync (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     ({spi_wr_tgl, spi_adv_tgl}),
        .q     (tgl_s)
    );

    shra_spi_link u_spi (
        .sclk    (SCLK),
        .rst_n   (RST_N),
        .cs_n    (CHIP_SELECT_N),
        .mosi    (SDA_I),
        .rd_data (SPI_RD_DATA),
        .rd_addr (SPI_RD_ADDR),
        .wr_addr (spi_wr_addr),
        .wr_data (spi_wr_data),
        .wr_tgl  (spi_wr_tgl),
        .adv_tgl (spi_adv_tgl),
        .sdo_o   (SDO_O),
        .sdo_oe  (SDO_OE)
    );

    assign scl_s      = pin_s[3];
    assign sda_s      = pin_s[2];
    assign i2c_en     = pin_s[1];
    assign scl_rise   = scl_s & ~scl_q_ff;
    assign scl_fall   = ~scl_s & scl_q_ff;
    assign bus_start  = i2c_en & scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    assign bus_stop   = i2c_en & scl_s & scl_q_ff & ~sda_q_ff & sda_s;
    assign byte_end   = scl_fall && (cnt_ff == `SHRA_BYTE_BITS);
    assign dev_hit    = (shift_ff[7:1] == {`SHRA_ADDR_FIXED, `SHRA_FACTORY_Y, addr_x_ff});
    assign hs_code    = (shift_ff[7:3] == `SHRA_HS_CODE);
    assign spi_wr_ev  = tgl_s[1] ^ tgl_q_ff[1];
    assign spi_adv_ev = tgl_s[0] ^ tgl_q_ff[0];
    assign at_buf     = (REG_ADDR == `SHRA_BUF_READ_ADDR);

    // edge history of synchronised pins and toggles
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            scl_q_ff <= 1'b0;
            sda_q_ff <= 1'b0;
            tgl_q_ff <= 2'h0;
        end else begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
            tgl_q_ff <= tgl_s;
        end
    end

    // address select strap followed until the first start, then frozen
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            addr_x_ff     <= 1'b0;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            addr_x_ff     <= pin_s[0]; // RULE19
            strap_done_ff <= bus_start;
        end
    end

    // i2c transfer sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            shra_pkg::S_DEV: begin
                if (byte_end) begin
                    nxt_state = (dev_hit && STARTUP_DONE) ? shra_pkg::S_DACK // RULE20
                                                          : shra_pkg::S_SKIP; // RULE21
                end
            end
            shra_pkg::S_DACK: begin
                if (scl_fall) begin
                    nxt_state = rw_ff ? shra_pkg::S_RDAT : shra_pkg::S_RA; // RULE5
                end
            end
            shra_pkg::S_RA: begin
                if (byte_end) begin
                    nxt_state = shra_pkg::S_RACK;
                end
            end
            shra_pkg::S_RACK, shra_pkg::S_WACK: begin
                if (scl_fall) begin
                    nxt_state = shra_pkg::S_WDAT; // RULE1
                end
            end
            shra_pkg::S_WDAT: begin
                if (byte_end) begin
                    nxt_state = shra_pkg::S_WACK;
                end
            end
            shra_pkg::S_RDAT: begin
                if (byte_end) begin
                    nxt_state = shra_pkg::S_MACK;
                end
            end
            shra_pkg::S_MACK: begin
                if (scl_fall) begin
                    nxt_state = mack_ok_ff ? shra_pkg::S_RDAT : shra_pkg::S_SKIP; // RULE6
                end
            end
            default: nxt_state = state_ff;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= shra_pkg::S_IDLE;
        end else if (!i2c_en || bus_stop) begin
            state_ff <= shra_pkg::S_IDLE;
        end else if (bus_start) begin
            state_ff <= shra_pkg::S_DEV;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // bit counter, restarted at every byte and acknowledge boundary
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cnt_ff <= 4'h0;
        end else if (bus_start || (nxt_state != state_ff)) begin
            cnt_ff <= 4'h0;
        end else if (scl_rise && cnt_ff != `SHRA_BYTE_BITS) begin
            cnt_ff <= 4'(cnt_ff + 4'h1);
        end
    end

    // receive shifter, direction bit and host acknowledge
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            shift_ff   <= 8'h00;
            rw_ff      <= 1'b0;
            mack_ok_ff <= 1'b0;
        end else begin
            if (scl_rise) begin
                shift_ff <= {shift_ff[6:0], sda_s};
            end
            if (state_ff == shra_pkg::S_DEV && byte_end) begin
                rw_ff <= shift_ff[0];
            end
            if (state_ff == shra_pkg::S_MACK && scl_rise) begin
                mack_ok_ff <= ~sda_s; // RULE6
            end
        end
    end

    // data line drive, changed on clock falls, released at start, stop or deselect
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            SDA_O  <= 1'b0;
            SDA_OE <= 1'b0;
            tx_ff  <= 8'h00;
        end else begin
            SDA_O <= 1'b0;
            if (!i2c_en || bus_start || bus_stop) begin
                SDA_OE <= 1'b0;
            end else if (scl_fall) begin
                case (state_ff)
                    shra_pkg::S_DEV: SDA_OE <= byte_end && dev_hit && STARTUP_DONE; // RULE19
                    shra_pkg::S_RA, shra_pkg::S_WDAT: SDA_OE <= byte_end; // RULE1
                    shra_pkg::S_DACK, shra_pkg::S_MACK: begin
                        if (nxt_state == shra_pkg::S_RDAT) begin
                            SDA_OE <= ~REG_RDATA[7]; // RULE5
                            tx_ff  <= {REG_RDATA[6:0], 1'b0};
                        end else begin
                            SDA_OE <= 1'b0;
                        end
                    end
                    shra_pkg::S_RDAT: begin
                        SDA_OE <= ~byte_end & ~tx_ff[7];
                        tx_ff  <= {tx_ff[6:0], 1'b0};
                    end
                    default: SDA_OE <= 1'b0;
                endcase
            end
        end
    end

    // register pointer shared by both links
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            REG_ADDR <= 8'h00;
        end else if (spi_wr_ev) begin
            REG_ADDR <= spi_wr_addr;
        end else if (state_ff == shra_pkg::S_RA && byte_end) begin
            REG_ADDR <= shift_ff;
        end else if (state_ff == shra_pkg::S_WACK && scl_fall) begin
            REG_ADDR <= 8'(REG_ADDR + `SHRA_ADDR_STEP); // RULE3
        end else if (state_ff == shra_pkg::S_MACK && scl_rise && !sda_s && !at_buf) begin
            REG_ADDR <= 8'(REG_ADDR + `SHRA_ADDR_STEP); // RULE7
        end
    end

    // write strobe and buffer advance
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            REG_WDATA <= 8'h00;
            REG_WR    <= 1'b0;
            BUF_ADV   <= 1'b0;
        end else begin
            REG_WR  <= 1'b0;
            BUF_ADV <= spi_adv_ev || // RULE8
                       (state_ff == shra_pkg::S_MACK && scl_rise && at_buf);
            if (spi_wr_ev) begin
                REG_WDATA <= spi_wr_data;
                REG_WR    <= 1'b1; // RULE15
            end else if (state_ff == shra_pkg::S_WDAT && byte_end) begin
                REG_WDATA <= shift_ff;
                REG_WR    <= 1'b1; // RULE1
            end
        end
    end

    // high-speed mode flag
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            HS_MODE <= 1'b0;
        end else if (bus_stop || !i2c_en) begin
            HS_MODE <= 1'b0; // RULE11
        end else if (state_ff == shra_pkg::S_DEV && byte_end && hs_code) begin
            HS_MODE <= 1'b1; // RULE10
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_data_byte_end;
        state_ff == shra_pkg::S_WDAT && byte_end && !spi_wr_ev;
    endsequence
    sequence s_one_strobe;
        REG_WR ##1 !REG_WR;
    endsequence
    sequence s_read_ack;
        state_ff == shra_pkg::S_MACK && scl_rise && !sda_s && i2c_en;
    endsequence

    AST_WRITE_STROBE: assert property ( // RULE1
        s_data_byte_end |=> s_one_strobe and (REG_WDATA == $past(shift_ff)))
        else $error("written byte was not strobed once");
    AST_WRITE_STEP: assert property ( // RULE3
        (state_ff == shra_pkg::S_WACK && scl_fall && !spi_wr_ev)
        |=> REG_ADDR == 8'($past(REG_ADDR) + 8'h01))
        else $error("write address did not step after ack");
    AST_READ_STEP: assert property ( // RULE7
        s_read_ack ##0 !at_buf |=> REG_ADDR == 8'($past(REG_ADDR) + 8'h01) && !BUF_ADV)
        else $error("read address did not step after host ack");
    AST_BUF_HOLD: assert property ( // RULE8
        s_read_ack ##0 at_buf |=> BUF_ADV && $stable(REG_ADDR))
        else $error("buffer port read moved the address");
    AST_HS_ENTER: assert property ( // RULE10
        (state_ff == shra_pkg::S_DEV && byte_end && hs_code && !bus_stop && i2c_en)
        |=> HS_MODE && !SDA_OE)
        else $error("master code did not enter high-speed mode");
    AST_HS_LEAVE: assert property ( // RULE11
        bus_stop |=> !HS_MODE)
        else $error("stop left high-speed mode set");
    AST_SDO_RELEASE: assert property ( // RULE12
        (i2c_en && $past(i2c_en, 2)) |-> !SDO_OE)
        else $error("spi data output driven while deselected");
    AST_ADDR_ACK: assert property ( // RULE19
        (state_ff == shra_pkg::S_DEV && byte_end && dev_hit && STARTUP_DONE
         && !bus_start && !bus_stop && i2c_en)
        |=> SDA_OE && state_ff == shra_pkg::S_DACK)
        else $error("own slave address was not acknowledged");
    AST_EARLY_NACK: assert property ( // RULE20
        (state_ff == shra_pkg::S_DEV && byte_end && !STARTUP_DONE) |=> !SDA_OE)
        else $error("acknowledged before startup completed");
    AST_FOREIGN_FREE: assert property ( // RULE21
        state_ff == shra_pkg::S_SKIP |-> !SDA_OE)
        else $error("data line driven for a foreign transfer");
endmodule // shra_front_end

/* File: test/shra_host.sv */
// host master model for i2c and 4-wire spi on the shared pins
`timescale 1ns/100ps
module shra_host (
    output logic      scl,
    output logic      cs_n,
    output logic      sda_low,
    output logic      mosi,
    input  wire logic sda,
    input  wire logic miso
);
    localparam int Q = 320;
    localparam int H = 32;

    initial begin
        scl = 1'b1;
        cs_n = 1'b1;
        sda_low = 1'b0;
        mosi = 1'b1;
    end

    task automatic i2c_start();
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask

    // stop only after the ack clock has ended
    task automatic i2c_stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask

    task automatic bit_xfer(input logic b, output logic r);
        #Q sda_low = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask

    // nack high releases the ack bit: on every address and written byte, and on the last read byte
    task automatic i2c_byte(input logic [7:0] d, input logic nack, output logic [7:0] q,
                            output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
            q[i] = r;
        end
        bit_xfer(nack, r);
        ack = ~r;
    endtask

    // one request per select, msb first, select high after
    task automatic spi_xfer(input logic [15:0] tx, output logic [7:0] rx);
        cs_n = 1'b0;
        #200;
        for (int i = 15; i >= 0; i--) begin
            scl = 1'b0;
            mosi = tx[i];
            #H scl = 1'b1;
            if (i < 8) rx[i] = miso;
            #H;
        end
        #H cs_n = 1'b1;
        mosi = ~mosi;
        #(4*H);
    endtask
endmodule // shra_host

/* File: test/tb_top.sv */
// self-checking bench of the register access front end
`timescale 1ns/100ps
`include "shra_defines.svh"
module tb_top;
    logic        clk_sys, rst_n, sclk, cs_n, sda_i, sda_o, sda_oe, sdo_o, sdo_oe;
    logic        addr_select, startup_done, reg_wr, buf_adv, hs_mode;
    logic [7:0]  reg_addr, reg_rdata, reg_wdata, spi_rd_addr, spi_rd_data, salt, ra;
    logic        sda_low, mosi, sda_line, miso, oe_seen;
    logic [7:0]  sad_w, q, rx;
    logic        a;
    logic [31:0] rnd;
    logic [15:0] wq[$];
    int          n_checks, n_mismatch, n_adv;

    shra_front_end u_shra_front_end (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .SCLK(sclk), .CHIP_SELECT_N(cs_n),
        .SDA_I(sda_i), .SDA_O(sda_o), .SDA_OE(sda_oe), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
        .ADDR_SELECT(addr_select), .STARTUP_DONE(startup_done), .REG_ADDR(reg_addr),
        .REG_RDATA(reg_rdata), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .BUF_ADV(buf_adv),
        .SPI_RD_ADDR(spi_rd_addr), .SPI_RD_DATA(spi_rd_data), .HS_MODE(hs_mode));

    shra_host u_shra_host (.scl(sclk), .cs_n(cs_n), .sda_low(sda_low), .mosi(mosi),
                           .sda(sda_line), .miso(miso));

    // pulled-up open-drain line, shared data pin, floating output seen inverted
    assign sda_line = ~((sda_oe & ~sda_o) | sda_low);
    assign sda_i = cs_n ? sda_line : mosi;
    assign miso = sdo_oe ? sdo_o : ~sdo_o;

    function automatic logic [7:0] reg_val(input logic [7:0] ad);
        return {ad[3:0], ad[7:4]} ^ salt;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    assign reg_rdata = reg_val(reg_addr);
    assign spi_rd_data = reg_val(spi_rd_addr);

    always #20 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
        if (buf_adv === 1'b1) n_adv++;
        if (sda_oe === 1'b1) oe_seen = 1'b1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic refused(input logic [7:0] slave_address_byte);
        oe_seen = 1'b0;
        u_shra_host.i2c_start();
        u_shra_host.i2c_byte(slave_address_byte, 1'b1, q, a);
        u_shra_host.i2c_stop();
        check(a, 1'b0, "refused address acked");
        check(oe_seen, 1'b0, "line driven when refused");
    endtask

    task automatic i2c_wr(input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1);
        logic [23:0] seq;
        wq.delete();
        seq = {r, d0, d1};
        u_shra_host.i2c_start();
        u_shra_host.i2c_byte(sad_w, 1'b1, q, a);
        check(a, 1'b1, "own address ack");
        for (int i = 2; i >= 0; i--) begin
            u_shra_host.i2c_byte(seq[8*i+:8], 1'b1, q, a);
            check(a, 1'b1, "byte ack");
        end
        u_shra_host.i2c_stop();
        repeat (8) @(posedge clk_sys);
        check(16'(wq.size()), 16'h0002, "write count");
        check(wq[0], {r, d0}, "first write");
        check(wq[1], {r + 8'h01, d1}, "second write");
    endtask

    task automatic i2c_rd(input logic [7:0] r, input int n);
        u_shra_host.i2c_start();
        u_shra_host.i2c_byte(sad_w, 1'b1, q, a);
        u_shra_host.i2c_byte(r, 1'b1, q, a);
        u_shra_host.i2c_start();
        u_shra_host.i2c_byte(sad_w | 8'h01, 1'b1, q, a);
        check(a, 1'b1, "read address ack");
        for (int i = 0; i < n; i++) begin
            u_shra_host.i2c_byte(8'hFF, i == n - 1, q, a);
            check(q, reg_val(r == 8'h5F ? r : r + 8'(i)), "read data");
        end
        u_shra_host.i2c_stop();
    endtask

    initial begin
        clk_sys = 1'b0;
        rnd = 32'h00012AE6;
        rst_n = 1'b0;
        startup_done = 1'b0;
        addr_select = rnd[1];
        salt = 8'h00;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sad_w = {`SHRA_ADDR_FIXED, `SHRA_FACTORY_Y, addr_select, 1'b0};
        refused(sad_w);
        startup_done <= 1'b1;
        refused({`SHRA_ADDR_FIXED, ~`SHRA_FACTORY_Y, addr_select, 1'b0});
        $display("test refusals done");
        rnd = lfsr(rnd);
        salt = rnd[7:0];
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(lfsr(rnd));
            ra = (k == 0) ? 8'hFE : {rnd[7:1], 1'b0};
            if (ra == 8'h5E) ra = 8'h20;
            i2c_wr(ra, rnd[15:8], rnd[23:16]);
            i2c_rd(ra, 2);
        end
        $display("test i2c bursts done");
        n_adv = 0;
        i2c_rd(8'h5F, 3);
        check(16'(n_adv), 16'h0003, "buffer advances");
        $display("test buffer port done");
        u_shra_host.i2c_start();
        u_shra_host.i2c_byte({5'h01, rnd[2:0]}, 1'b1, q, a);
        check(a, 1'b0, "master code acked");
        check(hs_mode, 1'b1, "high speed entered");
        u_shra_host.i2c_start();
        u_shra_host.i2c_byte(sad_w, 1'b1, q, a);
        check(a, 1'b1, "address ack in high speed");
        u_shra_host.i2c_stop();
        repeat (4) @(posedge clk_sys);
        check(hs_mode, 1'b0, "high speed left on stop");
        $display("test high speed done");
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(lfsr(rnd));
            wq.delete();
            u_shra_host.spi_xfer({1'b0, rnd[6:0], rnd[15:8]}, rx);
            repeat (8) @(posedge clk_sys);
            check(16'(wq.size()), 16'h0001, "spi write count");
            check(wq[0], {1'b0, rnd[6:0], rnd[15:8]}, "spi write");
            u_shra_host.spi_xfer({1'b1, rnd[22:16], 8'h00}, rx);
            repeat (8) @(posedge clk_sys);
            check(rx, reg_val({1'b0, rnd[22:16]}), "spi read data");
            check(16'(wq.size()), 16'h0001, "read caused write");
            check(sdo_oe, 1'b0, "output driven while deselected");
        end
        n_adv = 0;
        u_shra_host.spi_xfer({1'b1, 7'h5F, 8'h00}, rx);
        repeat (8) @(posedge clk_sys);
        check(rx, reg_val(8'h5F), "spi buffer data");
        check(16'(n_adv), 16'h0001, "spi buffer advance");
        $display("test spi done");
        give_verdict();
    end

    initial begin
        #3000000;
        n_mismatch++;
        give_verdict();
    end
endmodule // tb_top
